// ---- fec_defs.vh ----
// constants for the 4b/5b nibble-to-symbol codec
`ifndef FEC_DEFS_VH
`define FEC_DEFS_VH
`define FEC_SYM_IDLE  5'h1F
`define FEC_SYM_J     5'h18
`define FEC_SYM_K     5'h11
`define FEC_SYM_T     5'h0D
`define FEC_SYM_R     5'h07
`define FEC_SYM_H     5'h04
`define FEC_NIB_SSD   4'h5
`define FEC_NIB_BADSSD 4'hE
`define FEC_NIB_ZERO  4'h0
`define FEC_CLK_MHZ   100
`endif

// ---- fec_decode.v ----
// registered 5b-to-4b lookup for one received code-group
`timescale 1ns/1ns
`default_nettype none
`include "fec_defs.vh"
module fec_decode (
  // clock and reset
  input  wire       sys_clk,
  input  wire       sys_rst,
  // code-group in
  input  wire [4:0] symIn,
  // decoded nibble out
  output reg  [3:0] nibOut,
  output reg        isData
);
  reg [3:0] nibNext;
  reg       dataNext;

  // inverse data mapping, anything else is not data
  always @* begin
    dataNext = 1'b1;
    case (symIn)
      5'h1E: nibNext = 4'h0;
      5'h09: nibNext = 4'h1;
      5'h14: nibNext = 4'h2;
      5'h15: nibNext = 4'h3;
      5'h0A: nibNext = 4'h4;
      5'h0B: nibNext = 4'h5;
      5'h0E: nibNext = 4'h6;
      5'h0F: nibNext = 4'h7;
      5'h12: nibNext = 4'h8;
      5'h13: nibNext = 4'h9;
      5'h16: nibNext = 4'hA;
      5'h17: nibNext = 4'hB;
      5'h1A: nibNext = 4'hC;
      5'h1B: nibNext = 4'hD;
      5'h1C: nibNext = 4'hE;
      5'h1D: nibNext = 4'hF;
      default: begin
        nibNext  = `FEC_NIB_ZERO;
        dataNext = 1'b0;
      end
    endcase
  end

  // output register
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      nibOut <= `FEC_NIB_ZERO;
      isData <= 1'b0;
    end else begin
      nibOut <= nibNext;
      isData <= dataNext;
    end
  end
endmodule // fec_decode
`default_nettype wire

// ---- fec_codec.v ----
// 4b/5b transmit encoder and 5b/4b receive decoder for the 100M path
// Function
// - every transmitted nibble becomes one 5-bit symbol toward the scrambler
// - data nibbles 0..F map to sixteen fixed symbols; receive inverts
// - idle 11111 sent after T/R until tx enable rises; rx treats as idle
// - rising tx enable sends J then K; rx decodes J,K as 0101
// - tx error from MAC sends H symbol instead of data
// - invalid symbols never sent while encoding; received during valid raises error
// - bypass clear: nibble passes straight, fifth bit equals tx error
// - bad start pair raises error, drives 1110, valid stays low
// - valid rises on good start pair; drops on T or first idle, crs one cycle later on R or second idle
`timescale 1ns/1ns
`default_nettype none
`include "fec_defs.vh"
module fec_codec (
  // clock and reset
  input  wire       sys_clk,
  input  wire       sys_rst,
  // configuration (encoder enable bit; low bypasses)
  input  wire       encEnable,
  // transmit side from the MAC
  input  wire [3:0] txData,
  input  wire       txEn,
  input  wire       txEr,
  // transmit symbols toward scrambler
  output reg  [4:0] txSym,
  // receive symbols from descrambler
  input  wire [4:0] rxSym,
  // receive side toward the MAC
  output reg  [3:0] rxData,
  output reg        rxDv,
  output reg        rxEr,
  output reg        crs
);
  // transmit states
  localparam TX_IDLE = 3'd0;
  localparam TX_K    = 3'd1;
  localparam TX_DATA = 3'd2;
  localparam TX_R    = 3'd3;
  // receive states
  localparam RX_IDLE = 2'd0;
  localparam RX_K    = 2'd1;
  localparam RX_DATA = 2'd2;
  localparam RX_R    = 2'd3;

  reg [2:0] txState_reg;
  reg [2:0] txState_next;
  reg [4:0] txSym_next;
  reg [4:0] dataSym;

  // nibble to data symbol
  always @* begin
    case (txData)
      4'h0: dataSym = 5'h1E;
      4'h1: dataSym = 5'h09;
      4'h2: dataSym = 5'h14;
      4'h3: dataSym = 5'h15;
      4'h4: dataSym = 5'h0A;
      4'h5: dataSym = 5'h0B;
      4'h6: dataSym = 5'h0E;
      4'h7: dataSym = 5'h0F;
      4'h8: dataSym = 5'h12;
      4'h9: dataSym = 5'h13;
      4'hA: dataSym = 5'h16;
      4'hB: dataSym = 5'h17;
      4'hC: dataSym = 5'h1A;
      4'hD: dataSym = 5'h1B;
      4'hE: dataSym = 5'h1C;
      default: dataSym = 5'h1D;
    endcase
  end

  // transmit sequencer, only legal symbols are produced unless bypassed
  always @* begin
    txState_next = txState_reg;
    txSym_next   = `FEC_SYM_IDLE;
    case (txState_reg)
      TX_IDLE: begin
        if (txEn) begin
          txSym_next   = `FEC_SYM_J;
          txState_next = TX_K;
        end
      end
      TX_K: begin
        txSym_next   = `FEC_SYM_K;
        txState_next = TX_DATA;
      end
      TX_DATA: begin
        if (!txEn) begin
          txSym_next   = `FEC_SYM_T;
          txState_next = TX_R;
        end else if (txEr) begin
          txSym_next = `FEC_SYM_H;
        end else begin
          txSym_next = dataSym;
        end
      end
      TX_R: begin
        txSym_next   = `FEC_SYM_R;
        txState_next = TX_IDLE;
      end
      default: txState_next = TX_IDLE;
    endcase
    if (!encEnable) begin
      txSym_next   = {txEr, txData};
      txState_next = TX_IDLE;
    end
  end

  // transmit registers
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      txState_reg <= TX_IDLE;
      txSym       <= `FEC_SYM_IDLE;
    end else begin
      txState_reg <= txState_next;
      txSym       <= txSym_next;
    end
  end

  // receive: register symbol alongside the registered lookup
  wire [3:0] decNib;
  wire       decData;
  reg  [4:0] symD_reg;

  fec_decode uDecode (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .symIn   (rxSym),
    .nibOut  (decNib),
    .isData  (decData)
  );

  always @(posedge sys_clk) begin
    if (sys_rst)
      symD_reg <= `FEC_SYM_IDLE;
    else
      symD_reg <= rxSym;
  end

  reg [1:0] rxState_reg;
  reg [1:0] rxState_next;
  reg       idleSeen_reg;
  reg       idleSeen_next;
  reg [3:0] rxData_next;
  reg       rxDv_next;
  reg       rxEr_next;
  reg       crs_next;

  wire isIdle = (symD_reg == `FEC_SYM_IDLE);

  // receive sequencer
  always @* begin
    rxState_next  = rxState_reg;
    idleSeen_next = 1'b0;
    rxData_next   = `FEC_NIB_ZERO;
    rxDv_next     = 1'b0;
    rxEr_next     = 1'b0;
    crs_next      = crs;
    case (rxState_reg)
      RX_IDLE: begin
        crs_next = 1'b0;
        if (symD_reg == `FEC_SYM_J) begin
          rxState_next = RX_K;
          crs_next     = 1'b1;
          rxData_next  = `FEC_NIB_SSD;
        end else if (!isIdle) begin
          rxEr_next   = 1'b1;
          rxData_next = `FEC_NIB_BADSSD;
        end
      end
      RX_K: begin
        if (symD_reg == `FEC_SYM_K) begin
          rxState_next = RX_DATA;
          rxData_next  = `FEC_NIB_SSD;
          rxDv_next    = 1'b1;
        end else begin
          rxState_next = RX_IDLE;
          rxEr_next    = 1'b1;
          rxData_next  = `FEC_NIB_BADSSD;
          crs_next     = 1'b0;
        end
      end
      RX_DATA: begin
        rxDv_next = 1'b1;
        if (decData) begin
          rxData_next = decNib;
        end else if (symD_reg == `FEC_SYM_T) begin
          rxState_next = RX_R;
          rxDv_next    = 1'b0;
        end else if (isIdle && idleSeen_reg) begin
          rxState_next = RX_IDLE;
          rxDv_next    = 1'b0;
          crs_next     = 1'b0;
        end else if (isIdle) begin
          idleSeen_next = 1'b1;
          rxDv_next     = 1'b0;
        end else begin
          rxEr_next = 1'b1;
        end
      end
      RX_R: begin
        rxState_next = RX_IDLE;
        crs_next     = 1'b0;
        if (symD_reg != `FEC_SYM_R)
          rxEr_next = 1'b1;
      end
      default: rxState_next = RX_IDLE;
    endcase
  end

  // receive registers
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      rxState_reg  <= RX_IDLE;
      idleSeen_reg <= 1'b0;
      rxData       <= `FEC_NIB_ZERO;
      rxDv         <= 1'b0;
      rxEr         <= 1'b0;
      crs          <= 1'b0;
    end else begin
      rxState_reg  <= rxState_next;
      idleSeen_reg <= idleSeen_next;
      rxData       <= rxData_next;
      rxDv         <= rxDv_next;
      rxEr         <= rxEr_next;
      crs          <= crs_next;
    end
  end
endmodule // fec_codec
`default_nettype wire

// ---- fec_codec_props.sv ----
// assertions on the ports of the 4b/5b codec
`timescale 1ns/1ns
`default_nettype none
module fec_codec_props (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  // transmit side
  input wire logic       encEnable,
  input wire logic [3:0] txData,
  input wire logic       txEn,
  input wire logic       txEr,
  input wire logic [4:0] txSym,
  // receive side
  input wire logic [4:0] rxSym,
  input wire logic [3:0] rxData,
  input wire logic       rxDv,
  input wire logic       rxEr,
  input wire logic       crs
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // start pair on rising enable
  property p_jk;
    !txEn [*3] ##1 (txEn && encEnable) |=> txSym == 5'h18 ##1 txSym == 5'h11;
  endproperty
  a_jk: assert property (p_jk) else $error("start pair wrong");
  // end pair on falling enable
  property p_tr;
    (txEn && encEnable) [*3] ##1 (!txEn && encEnable)
      |=> txSym == 5'h0D ##1 txSym == 5'h07;
  endproperty
  a_tr: assert property (p_tr) else $error("end pair wrong");
  // error symbol replaces data
  property p_h;
    (txEn && encEnable) [*3] ##1 (txEn && txEr && encEnable)
      |=> txSym == 5'h04;
  endproperty
  a_h: assert property (p_h) else $error("error symbol wrong");
  // idle after the end pair
  property p_idle;
    (!txEn && encEnable) [*3] |=> txSym == 5'h1F;
  endproperty
  a_idle: assert property (p_idle) else $error("idle wrong");
  // bypass passes nibble and error bit
  property p_byp;
    !encEnable |=> txSym == {$past(txEr), $past(txData)};
  endproperty
  a_byp: assert property (p_byp) else $error("bypass wrong");
  // bad start pair
  property p_ssd;
    !crs && !rxDv && rxSym == 5'h00 |-> ##2 rxEr && rxData == 4'hE && !rxDv;
  endproperty
  a_ssd: assert property (p_ssd) else $error("bad start wrong");
  // good start pair raises valid
  property p_sof;
    (rxSym == 5'h1F && !crs) [*2] ##1 rxSym == 5'h18 ##1 rxSym == 5'h11
      |-> ##2 rxDv && crs && rxData == 4'h5;
  endproperty
  a_sof: assert property (p_sof) else $error("start decode wrong");
  // invalid code-group inside a frame
  property p_inv;
    rxDv && $past(rxSym) == 5'h1E && rxSym == 5'h00 |-> ##2 rxEr && rxDv;
  endproperty
  a_inv: assert property (p_inv) else $error("invalid not flagged");
  // end pair drops valid then carrier
  property p_esd;
    rxDv && rxSym == 5'h0D ##1 rxSym == 5'h07 |-> ##1 !rxDv ##1 !crs;
  endproperty
  a_esd: assert property (p_esd) else $error("end decode wrong");
  // two idles inside a frame end it
  property p_ii;
    rxDv && rxSym == 5'h1F ##1 rxSym == 5'h1F |-> ##2 !crs && !rxDv;
  endproperty
  a_ii: assert property (p_ii) else $error("idle end wrong");
  // only legal code-groups leave the encoder
  property p_legal;
    $past(encEnable) |-> txSym inside {5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A,
      5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C,
      5'h1D, 5'h1F, 5'h18, 5'h11, 5'h0D, 5'h07, 5'h04};
  endproperty
  a_legal: assert property (p_legal) else $error("illegal symbol sent");
endmodule // fec_codec_props
`default_nettype wire

// ---- fec_line_model.sv ----
// line model: loops symbols back or injects chosen ones
`timescale 1ns/1ns
`default_nettype none
module fec_line_model (
  input  wire logic       sys_clk,
  input  wire logic [4:0] txSym,
  input  wire logic       injOn,
  input  wire logic [4:0] injSym,
  output var  logic [4:0] rxSym
);
  // one symbol per clock, as the descrambler hands them over
  always @(posedge sys_clk) rxSym <= injOn ? injSym : txSym;
endmodule // fec_line_model
`default_nettype wire

// ---- fec_codec_tb_top.sv ----
// testbench for the codec, transmit looped back into receive
`timescale 1ns/1ns
`default_nettype none
module fec_codec_tb_top;
  logic       sys_clk = 0, sys_rst = 1, encEnable = 1, txEn = 0, txEr = 0;
  logic       rxDv, rxEr, crs, injOn = 0, byErr;
  logic [3:0] txData = 0, rxData, byNib;
  logic [4:0] txSym, rxSym, injSym = 0;
  logic [4:0] rq[$];
  int         fails = 0, n_checks = 0;
  always #5 sys_clk = ~sys_clk;
  fec_codec dut (.sys_clk, .sys_rst, .encEnable, .txData, .txEn, .txEr,
    .txSym, .rxSym, .rxData, .rxDv, .rxEr, .crs);
  fec_line_model line (.sys_clk, .txSym, .injOn, .injSym, .rxSym);
  // expected code-group of a data nibble
  function automatic logic [4:0] enc(logic [3:0] n);
    logic [4:0] t[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
      5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    return t[n];
  endfunction
  task automatic check(string nm, logic [5:0] got, logic [5:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // one cycle: drive, compare this symbol and the nibble of three steps back
  task automatic step(logic en, er, logic [3:0] d, logic [4:0] e, q);
    txEn = en;
    txEr = er;
    txData = d;
    rq.push_back(q);
    @(negedge sys_clk);
    check("txSym", txSym, e);
    if (rq.size() > 3) begin
      q = rq.pop_front();
      if (q[4]) check("rxData", {crs, rxDv, rxData}, {1'b1, q});
    end
  endtask
  task automatic frame(int n);
    logic [3:0] d;
    logic       er;
    step(1, 0, 0, 5'h18, 0);
    step(1, 0, 0, 5'h11, 5'h15);
    repeat (n) begin
      d = $urandom;
      er = ($urandom % 6) == 0;
      step(1, er, d, er ? 5'h04 : enc(d), er ? 5'h00 : {1'b1, d});
    end
    step(0, 0, 0, 5'h0D, 0);
    step(0, 0, 0, 5'h07, 0);
    repeat (3) step(0, 0, 0, 5'h1F, 0);
    $display("frame of %0d nibbles done", n);
  endtask
  task automatic close_out;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // line sequence: bad start, frame with invalid group, frame ended by idles
  logic [4:0] seq[22] = '{5'h1F, 5'h1F, 5'h00, 5'h1F, 5'h1F, 5'h18, 5'h11,
    5'h1E, 5'h00, 5'h1E, 5'h0D, 5'h07, 5'h1F, 5'h1F, 5'h18, 5'h11, 5'h1E,
    5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1F};
  initial begin
    void'($urandom(4));
    repeat (16) @(negedge sys_clk);
    sys_rst = 0;
    repeat (3) step(0, 0, 0, 5'h1F, 0);
    frame(1);
    repeat (4) frame($urandom_range(2, 20));
    encEnable = 0;
    repeat (8) begin
      byNib = $urandom;
      byErr = $urandom;
      step(0, byErr, byNib, {byErr, byNib}, 0);
    end
    $display("bypass done");
    encEnable = 1;
    repeat (3) step(0, 0, 0, 5'h1F, 0);
    injOn = 1;
    for (int i = 0; i < 22; i++) begin
      injSym = seq[i];
      if (i == 5) check("badStart", {rxEr, rxDv, rxData}, 6'h2E);
      if (i == 11) check("invalid", {4'h0, rxEr, rxDv}, 6'h03);
      if (i == 19) check("idleFrame", {crs, rxDv, rxData}, 6'h30);
      if (i == 21) check("idleEnd", {rxEr, crs, rxDv}, 6'h00);
      @(negedge sys_clk);
    end
    injOn = 0;
    rq.delete();
    $display("inject done");
    frame(6);
    close_out();
  end
endmodule // fec_codec_tb_top
bind fec_codec fec_codec_props chk (.sys_clk, .sys_rst, .encEnable, .txData,
  .txEn, .txEr, .txSym, .rxSym, .rxData, .rxDv, .rxEr, .crs);
`default_nettype wire
